// [tpwm_consts.svh]
// Register offsets, field positions, reset values and counts of the PWM timer
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

// Word offsets on the Avalon word bus
`define TPWM_OFF_CTRL_ONE   4'h0
`define TPWM_OFF_CTRL_TWO   4'h1
`define TPWM_OFF_STATUS     4'h2
`define TPWM_OFF_EDGE_HI    4'h3
`define TPWM_OFF_EDGE_LO    4'h4
`define TPWM_OFF_PERIOD_HI  4'h5
`define TPWM_OFF_PERIOD_LO  4'h6
`define TPWM_OFF_CAP2_HI    4'h7
`define TPWM_OFF_CAP2_LO    4'h8
`define TPWM_OFF_COUNT_HI   4'h9
`define TPWM_OFF_COUNT_LO   4'ha

// Control one fields
`define TPWM_C1_LVL_EDGE    0
`define TPWM_C1_LVL_PERIOD  1
`define TPWM_C1_CAP_IRQ_EN  7
// Control two fields
`define TPWM_C2_CLK_SEL_LO  0
`define TPWM_C2_SINGLE      4
`define TPWM_C2_PWM         5
`define TPWM_C2_EDGE_PIN_EN 7
// Status fields
`define TPWM_ST_CAP1        7
`define TPWM_ST_CAP2        5
`define TPWM_ST_OC1         6
`define TPWM_ST_OC2         4

`define TPWM_CTRL_RESET     8'h00
`define TPWM_CMP_RESET      16'h0000
`define TPWM_CNT_RELOAD     16'hfffc
`define TPWM_CNT_RESET      16'hfffc
`define TPWM_UNDEF_READ     8'h00

// Clock select codes and prescale dividers minus one
`define TPWM_CS_DIV4        2'h0
`define TPWM_CS_DIV2        2'h1
`define TPWM_CS_DIV8        2'h2
`define TPWM_CS_EXT         2'h3
`define TPWM_PRE_DIV2_M1    3'h1
`define TPWM_PRE_DIV4_M1    3'h3
`define TPWM_PRE_DIV8_M1    3'h7

`endif

// [tpwm_pkg.sv]
// Types shared by the PWM timer
package tpwm_pkg;

  typedef struct packed {
    logic [3:0] address;
    logic       read;
    logic       write;
    logic [31:0] writedata;
  } tpwm_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tpwm_avs_rsp_t;

  typedef enum logic [1:0] {
    TPWM_BUS_IDLE = 2'b00,
    TPWM_BUS_ACK  = 2'b01
  } tpwm_bus_state_t;

  typedef struct packed {
    tpwm_bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [15:0] edge_cmp;
    logic [15:0] period_cmp;
    logic [15:0] edge_act;
    logic [15:0] period_act;
    logic        edge_hold;
    logic        period_hold;
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic        ext_d;
    logic        cap2_d;
    logic [15:0] cap2_val;
    logic        cap1_flag;
    logic        cap2_flag;
    logic        pin;
  } tpwm_state_t;

endpackage

// [tpwm_timer.sv]
// PWM mode of a 16-bit timer with Avalon-MM register access
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module tpwm_timer (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Avalon-MM slave
  input  wire tpwm_pkg::tpwm_avs_req_t avs_req,
  output tpwm_pkg::tpwm_avs_rsp_t   avs_rsp,
  // CPU side
  input  wire logic                 cpu_irq_mask,
  input  wire logic                 halt_mode,
  output logic                      timer_irq,
  // Pins
  input  wire logic                 ext_timer_clk,
  input  wire logic                 first_capture_pin,
  input  wire logic                 second_capture_pin,
  output logic                      waveform_out_pin
);
  import tpwm_pkg::*;

  // Build option: the flash variant drops capture two; the period bytes read as undefined in every build
  localparam logic FLASH_VARIANT = 1'b1;

  tpwm_state_t s_reg;
  tpwm_state_t s_next;

  function automatic logic [2:0] pre_limit(input logic [1:0] sel);
    unique case (sel)
      `TPWM_CS_DIV2: pre_limit = `TPWM_PRE_DIV2_M1;
      `TPWM_CS_DIV4: pre_limit = `TPWM_PRE_DIV4_M1;
      `TPWM_CS_DIV8: pre_limit = `TPWM_PRE_DIV8_M1;
      `TPWM_CS_EXT:  pre_limit = `TPWM_PRE_DIV2_M1;
    endcase
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  logic       pwm_on;
  logic       tick;
  logic       edge_hit;
  logic       period_hit;
  logic       wr;
  logic       rd;
  logic       rd_done;
  logic [7:0] wb;

  always_comb begin
    pwm_on = s_reg.ctrl_two[`TPWM_C2_PWM];
    // Writes and read side effects land at the edge where waitrequest is low
    wr      = avs_req.write && (s_reg.bus == TPWM_BUS_ACK);
    rd      = avs_req.read && !avs_req.write && (s_reg.bus == TPWM_BUS_IDLE);
    rd_done = avs_req.read && !avs_req.write && (s_reg.bus == TPWM_BUS_ACK);
    wb     = avs_req.writedata[7:0];
    // Tick: prescaler wrap or rising external edge, frozen in halt
    if (halt_mode) begin
      tick = 1'b0;
    end else if (s_reg.ctrl_two[`TPWM_C2_CLK_SEL_LO +: 2] == `TPWM_CS_EXT) begin
      tick = ext_timer_clk && !s_reg.ext_d;
    end else begin
      tick = (s_reg.pre == pre_limit(s_reg.ctrl_two[`TPWM_C2_CLK_SEL_LO +: 2]));
    end
    // Match is suppressed while a high byte waits for its low byte
    edge_hit   = pwm_on && tick && !s_reg.edge_hold
                 && (s_reg.cnt == s_reg.edge_act);
    period_hit = pwm_on && tick && !s_reg.period_hold
                 && (s_reg.cnt == s_reg.period_act);
  end

  always_comb begin
    s_next = s_reg;
    // Prescaler runs except in halt and external clock mode so rate changes take effect quickly
    if (!halt_mode) begin
      if (tick || s_reg.ctrl_two[`TPWM_C2_CLK_SEL_LO +: 2] == `TPWM_CS_EXT) begin
        s_next.pre = 3'h0;
      end else begin
        s_next.pre = s_reg.pre + 3'h1;
      end
    end
    s_next.ext_d  = ext_timer_clk;
    s_next.cap2_d = second_capture_pin;

    if (period_hit) begin
      s_next.cnt        = `TPWM_CNT_RELOAD;
      s_next.edge_act   = s_reg.edge_cmp;
      s_next.period_act = s_reg.period_cmp;
      s_next.pin        = s_reg.ctrl_one[`TPWM_C1_LVL_PERIOD];
      s_next.cap1_flag  = 1'b1;
    end else if (tick) begin
      s_next.cnt = s_reg.cnt + 16'h0001;
      if (edge_hit) begin
        s_next.pin = s_reg.ctrl_one[`TPWM_C1_LVL_EDGE];
      end
    end
    if (!pwm_on) begin
      // Outside PWM the compares follow software directly
      s_next.edge_act   = s_reg.edge_cmp;
      s_next.period_act = s_reg.period_cmp;
    end

    // Capture two: counter restarts each period, so values are period-relative
    if (!FLASH_VARIANT && second_capture_pin && !s_reg.cap2_d) begin
      s_next.cap2_val  = s_reg.cnt;
      s_next.cap2_flag = 1'b1;
    end

    // Bus: one wait cycle, answer in the following cycle
    unique case (s_reg.bus)
      TPWM_BUS_IDLE: begin
        if (avs_req.read || avs_req.write) begin
          s_next.bus = TPWM_BUS_ACK;
        end
      end
      TPWM_BUS_ACK: begin
        s_next.bus = TPWM_BUS_IDLE;
      end
      default: s_next.bus = TPWM_BUS_IDLE;
    endcase

    if (wr) begin
      unique case (avs_req.address)
        `TPWM_OFF_CTRL_ONE: s_next.ctrl_one = wb;
        `TPWM_OFF_CTRL_TWO: s_next.ctrl_two = wb;
        `TPWM_OFF_EDGE_HI: begin
          s_next.edge_cmp[15:8] = wb;
          s_next.edge_hold      = 1'b1;
        end
        `TPWM_OFF_EDGE_LO: begin
          s_next.edge_cmp[7:0] = wb;
          s_next.edge_hold     = 1'b0;
        end
        `TPWM_OFF_PERIOD_HI: begin
          s_next.period_cmp[15:8] = wb;
          s_next.period_hold      = 1'b1;
        end
        `TPWM_OFF_PERIOD_LO: begin
          s_next.period_cmp[7:0] = wb;
          s_next.period_hold     = 1'b0;
        end
        default: ;
      endcase
    end

    if (rd) begin
      unique case (avs_req.address)
        `TPWM_OFF_CTRL_ONE: s_next.rdata = byte_word(s_reg.ctrl_one);
        `TPWM_OFF_CTRL_TWO: s_next.rdata = byte_word(s_reg.ctrl_two);
        `TPWM_OFF_STATUS: begin
          s_next.rdata = 32'h00000000;
          s_next.rdata[`TPWM_ST_CAP1] = s_reg.cap1_flag;
          s_next.rdata[`TPWM_ST_CAP2] = s_reg.cap2_flag;
          s_next.rdata[`TPWM_ST_OC1]  = 1'b0;
          s_next.rdata[`TPWM_ST_OC2]  = 1'b0;
        end
        `TPWM_OFF_EDGE_HI:   s_next.rdata = byte_word(s_reg.edge_cmp[15:8]);
        `TPWM_OFF_EDGE_LO:   s_next.rdata = byte_word(s_reg.edge_cmp[7:0]);
        `TPWM_OFF_PERIOD_HI: s_next.rdata = byte_word(`TPWM_UNDEF_READ);
        `TPWM_OFF_PERIOD_LO: s_next.rdata = byte_word(`TPWM_UNDEF_READ);
        `TPWM_OFF_CAP2_HI:   s_next.rdata = byte_word(s_reg.cap2_val[15:8]);
        `TPWM_OFF_CAP2_LO:   s_next.rdata = byte_word(s_reg.cap2_val[7:0]);
        `TPWM_OFF_COUNT_HI:  s_next.rdata = byte_word(s_reg.cnt[15:8]);
        `TPWM_OFF_COUNT_LO:  s_next.rdata = byte_word(s_reg.cnt[7:0]);
        default:             s_next.rdata = 32'h00000000;
      endcase
    end
    // Reading capture-two low clears the flags; a new event wins
    if (rd_done && avs_req.address == `TPWM_OFF_CAP2_LO) begin
      s_next.cap1_flag = period_hit;
      s_next.cap2_flag = !FLASH_VARIANT && second_capture_pin && !s_reg.cap2_d;
    end
    if (wr && avs_req.address == `TPWM_OFF_STATUS) begin
      // Write one to clear; set on the same cycle wins
      if (wb[`TPWM_ST_CAP1] && !period_hit) begin
        s_next.cap1_flag = 1'b0;
      end
      if (wb[`TPWM_ST_CAP2]) begin
        s_next.cap2_flag = !FLASH_VARIANT && second_capture_pin && !s_reg.cap2_d;
      end
    end
    if (FLASH_VARIANT) begin
      s_next.cap2_flag = 1'b0;
      s_next.cap2_val  = 16'h0000;
    end
    // First capture pin is never sampled here: disconnected in PWM
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg             <= '0;
      s_reg.bus         <= TPWM_BUS_IDLE;
      s_reg.ctrl_one    <= `TPWM_CTRL_RESET;
      s_reg.ctrl_two    <= `TPWM_CTRL_RESET;
      s_reg.edge_cmp    <= `TPWM_CMP_RESET;
      s_reg.period_cmp  <= `TPWM_CMP_RESET;
      s_reg.cnt         <= `TPWM_CNT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    avs_rsp.readdata    = s_reg.rdata;
    avs_rsp.waitrequest = (avs_req.read || avs_req.write) && (s_reg.bus == TPWM_BUS_IDLE);
    // Pin belongs to the waveform only with the edge pin enabled
    waveform_out_pin = s_reg.ctrl_two[`TPWM_C2_EDGE_PIN_EN] && s_reg.pin;
    timer_irq = s_reg.cap1_flag && s_reg.ctrl_one[`TPWM_C1_CAP_IRQ_EN]
                && !cpu_irq_mask;
  end

  logic unused_pin;
  assign unused_pin = first_capture_pin;

endmodule // tpwm_timer

// [tpwm_timer_assertions.sv]
// Port assertions of the PWM timer
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module tpwm_chk (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  // Bus, CPU side and pin
  input wire tpwm_pkg::tpwm_avs_req_t avs_req,
  input wire tpwm_pkg::tpwm_avs_rsp_t avs_rsp,
  input wire logic                    cpu_irq_mask,
  input wire logic                    halt_mode,
  input wire logic                    timer_irq,
  input wire logic                    waveform_out_pin
);
  import tpwm_pkg::*;
  wire logic req = avs_req.read | avs_req.write;
  wire logic busy = avs_rsp.waitrequest;
  wire logic rdone = avs_req.read & !avs_rsp.waitrequest;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wait_first_a: assert property (req && !$past(req) |-> busy)
    else $error("request answered without wait cycle");
  wait_one_a: assert property (req && busy ##1 req |-> !busy)
    else $error("request held more than one wait cycle");
  period_read_a: assert property (rdone && avs_req.address inside
    {`TPWM_OFF_PERIOD_HI, `TPWM_OFF_PERIOD_LO} |-> avs_rsp.readdata == {24'h0, `TPWM_UNDEF_READ})
    else $error("period byte read not undefined value");
  cap_two_read_a: assert property (rdone && avs_req.address inside
    {`TPWM_OFF_CAP2_HI, `TPWM_OFF_CAP2_LO} |-> avs_rsp.readdata == 32'h0)
    else $error("absent capture register read nonzero");
  status_zero_a: assert property (rdone && avs_req.address == `TPWM_OFF_STATUS
    |-> avs_rsp.readdata[6:4] == 3'h0)
    else $error("compare or second capture flag set");
  irq_mask_a: assert property (cpu_irq_mask |-> !timer_irq)
    else $error("interrupt while masked");
  halt_pin_a: assert property ($past(halt_mode) && !$past(avs_req.write)
    |-> $stable(waveform_out_pin))
    else $error("pin moved while halted");
  reset_quiet_a: assert property ($rose(rst_b) |-> !waveform_out_pin && !timer_irq)
    else $error("pin or interrupt active after reset");
endmodule // tpwm_chk

// [tpwm_load.sv]
// Load on the waveform pin, timing each pulse
`timescale 1ns/1ps
module tpwm_load (
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_b,
  // Observed pin and its timing in clocks
  input  wire logic   waveform_out_pin,
  output logic [15:0] high_len,
  output logic [15:0] period_len,
  output logic [15:0] rise_cnt
);
  logic        pin_d;
  logic [15:0] now, rise_at;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {pin_d, now, rise_at, high_len, period_len, rise_cnt} <= '0;
    end else begin
      pin_d <= waveform_out_pin;
      now <= now + 16'd1;
      if (waveform_out_pin && !pin_d) begin
        rise_at <= now;
        period_len <= now - rise_at;
        rise_cnt <= rise_cnt + 16'd1;
      end
      if (!waveform_out_pin && pin_d) begin
        high_len <= now - rise_at;
      end
    end
  end
endmodule // tpwm_load

// [tpwm_timer_test.sv]
// Self-checking bench of the PWM timer
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module tpwm_timer_test;
  import tpwm_pkg::*;
  logic          ref_clk, rst_b, cpu_irq_mask, halt_mode, timer_irq, ext_timer_clk;
  logic          first_capture_pin, second_capture_pin, waveform_out_pin;
  tpwm_avs_req_t avs_req;
  tpwm_avs_rsp_t avs_rsp;
  logic [15:0]   high_len, period_len, rise_cnt, c, per, edg;
  logic [31:0]   seed, rd;
  int            failures, checked;
  tpwm_timer tpwm_timer_i (.ref_clk(ref_clk), .rst_b(rst_b), .avs_req(avs_req),
    .avs_rsp(avs_rsp), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
    .timer_irq(timer_irq), .ext_timer_clk(ext_timer_clk),
    .first_capture_pin(first_capture_pin), .second_capture_pin(second_capture_pin),
    .waveform_out_pin(waveform_out_pin));
  tpwm_load tpwm_load_i (.ref_clk(ref_clk), .rst_b(rst_b), .waveform_out_pin(waveform_out_pin),
    .high_len(high_len), .period_len(period_len), .rise_cnt(rise_cnt));
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Clocks per counter tick; external clock toggles every 3 cycles
  function automatic int ticks(input logic [1:0] cs);
    return cs == `TPWM_CS_DIV2 ? 2 : cs == `TPWM_CS_DIV4 ? 4 : cs == `TPWM_CS_DIV8 ? 8 : 6;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_req <= '{address: adr, read: !wr, write: wr, writedata: {24'h0, wd}};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_rsp.waitrequest !== 1'b0 && k < 100);
    rd = avs_rsp.readdata;
    avs_req <= '0;
    check("bus answer", k < 100, 1'b1);
  endtask
  task automatic wait_rises(input logic [15:0] cnt);
    int k;
    c = rise_cnt;
    k = 0;
    while (rise_cnt - c < cnt && k < 8000) begin
      @(posedge ref_clk);
      k++;
    end
    check("rise wait", k < 8000, 1'b1);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always begin
    repeat (3) @(posedge ref_clk);
    ext_timer_clk <= ~ext_timer_clk;
  end
  // Capture pins must not disturb the waveform
  always @(posedge ref_clk) begin
    {first_capture_pin, second_capture_pin} <= 2'(next_rand());
  end
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    seed = 32'hcbd4;
    failures = 0;
    checked = 0;
    avs_req = '0;
    {cpu_irq_mask, halt_mode, ext_timer_clk} = 3'h4;
    {first_capture_pin, second_capture_pin} = 2'h0;
    rst_b = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Counter bytes skipped: it may already be running
    for (int a = 0; a < 16; a++) begin
      if (a != 9 && a != 10) begin
        bus(1'b0, 4'(a), 8'h00);
        check("reset read", rd, {24'h0, `TPWM_CTRL_RESET});
      end
    end
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      per = 16'd40 + 16'(next_rand() % 40);
      edg = 16'd1 + 16'(next_rand() % 38);
      // Freeze ticks so a held compare cannot miss its match and wrap
      halt_mode <= 1'b1;
      bus(1'b1, `TPWM_OFF_PERIOD_HI, per[15:8]);
      bus(1'b1, `TPWM_OFF_PERIOD_LO, per[7:0]);
      bus(1'b1, `TPWM_OFF_EDGE_HI, edg[15:8]);
      bus(1'b1, `TPWM_OFF_EDGE_LO, edg[7:0]);
      bus(1'b1, `TPWM_OFF_CTRL_ONE, 8'h81);
      bus(1'b1, `TPWM_OFF_CTRL_TWO, {3'h5, m[0], 2'h0, m[1:0]});
      halt_mode <= 1'b0;
      wait_rises(16'd3);
      check("high time", high_len, (per - edg) * ticks(2'(m)));
      check("period", period_len, (per + 16'd5) * ticks(2'(m)));
      $display("pwm mode %0d done", m);
    end
    bus(1'b0, `TPWM_OFF_STATUS, 8'h00);
    check("capture flag", rd[7], 1'b1);
    cpu_irq_mask <= 1'b0;
    @(posedge ref_clk);
    #1 check("irq unmasked", timer_irq, 1'b1);
    halt_mode <= 1'b1;
    bus(1'b1, `TPWM_OFF_STATUS, 8'h80);
    bus(1'b0, `TPWM_OFF_STATUS, 8'h00);
    check("flag cleared", rd[7], 1'b0);
    bus(1'b0, `TPWM_OFF_COUNT_LO, 8'h00);
    c = rd[15:0];
    repeat (20) @(posedge ref_clk);
    bus(1'b0, `TPWM_OFF_COUNT_LO, 8'h00);
    check("halted count", rd[15:0], c);
    cpu_irq_mask <= 1'b1;
    halt_mode <= 1'b0;
    $display("irq and halt test done");
    for (int lv = 0; lv < 4; lv += 3) begin
      bus(1'b1, `TPWM_OFF_CTRL_ONE, 8'(lv));
      repeat (1000) @(posedge ref_clk);
      c = rise_cnt;
      repeat (1000) @(posedge ref_clk);
      check("steady rises", rise_cnt, c);
      check("steady level", waveform_out_pin, lv[0]);
    end
    $display("steady level test done");
    results();
  end
endmodule // tpwm_timer_test
bind tpwm_timer tpwm_chk tpwm_chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
  .timer_irq(timer_irq), .waveform_out_pin(waveform_out_pin));
